// [cpu_core_params.svh]
`ifndef CPU_CORE_PARAMS_SVH
`define CPU_CORE_PARAMS_SVH

// ****************************************
// program counter and program memory
// ****************************************
`define PC_WIDTH 15
`define PWORD_WIDTH 14
`define PMEM_WORDS 4096
`define PMEM_AW 12
`define PMEM_LAST 15'h0fff
`define RESET_VECTOR 15'h0000
`define IRQ_VECTOR 15'h0004

// ****************************************
// return stack
// ****************************************
`define STACK_DEPTH 16
`define STACK_AW 4
`define STACK_CW 5

// ****************************************
// indirect pointers
// ****************************************
`define PTR_WIDTH 16
`define PTR_PMEM_BIT 15
`define PM_EXTRA_CYCLES 1
`define DADDR_WIDTH 12
`define LIN_BASE 16'h2000
`define LIN_LAST 16'h29af
`define GPR_PER_BANK 80
`define GPR_FIRST 7'h20

// ****************************************
// instruction set
// ****************************************
`define INSN_COUNT 49

`endif

// [cpu_core_pkg.sv]
package cpu_core_pkg;

    typedef enum logic [2:0] {
        SEQ_HOLD,
        SEQ_NEXT,
        SEQ_JUMP,
        SEQ_CALL,
        SEQ_RETURN,
        SEQ_RETFIE,
        SEQ_IRQ
    } seqop_t;

    typedef enum logic [1:0] {
        IX_IDLE,
        IX_PMWAIT
    } ixstate_t;

endpackage

// [cpu_pc_stack_fsr_core.sv]
`timescale 1ns/1ns
`include "cpu_core_params.svh"

module cpu_pc_stack_fsr_core
    import cpu_core_pkg::*;
(
    input wire logic clk_sys,
    input wire logic resetn,
    input wire seqop_t seqOp,
    input wire logic [`PC_WIDTH-1:0] jumpTarget,
    input wire logic stackResetEnable,
    input wire logic clearStackFlags,
    input wire logic [7:0] ctxWreg,
    input wire logic [4:0] ctxStatus,
    input wire logic [4:0] ctxBsr,
    input wire logic [6:0] ctxPclath,
    input wire logic [1:0] ptrWrite,
    input wire logic ptrHighByte,
    input wire logic [7:0] ptrWdata,
    input wire logic indReq,
    input wire logic indWrite,
    input wire logic indSel,
    input wire logic [7:0] indWdata,
    input wire logic [`PWORD_WIDTH-1:0] progData,
    output logic [`PC_WIDTH-1:0] pc,
    output logic [`PMEM_AW-1:0] progAddr,
    output logic stall,
    output logic [7:0] indRdata,
    output logic indRdValid,
    output logic [`DADDR_WIDTH-1:0] dataAddr,
    output logic dataRe,
    output logic dataWe,
    output logic [7:0] dataWdata,
    output logic [`PTR_WIDTH-1:0] ptr0,
    output logic [`PTR_WIDTH-1:0] ptr1,
    output logic stack_overflow_flag,
    output logic stack_underflow_flag,
    output logic softReset,
    output logic restoreValid,
    output logic [7:0] shadowWreg,
    output logic [4:0] shadowStatus,
    output logic [4:0] shadowBsr,
    output logic [6:0] shadowPclath
);
    // ****************************************
    // decode functions
    // ****************************************
    function automatic logic [`PC_WIDTH-1:0] wrapPc(
        input logic [`PC_WIDTH-1:0] a
    );
        wrapPc = a & `PMEM_LAST;
    endfunction

    // linear window folds onto the gpr area of banks 0 to 30
    function automatic logic [`DADDR_WIDTH-1:0] dataMap(
        input logic [`PTR_WIDTH-1:0] p
    );
        logic [`PTR_WIDTH-1:0] lin;
        logic [`PTR_WIDTH-1:0] bank;
        logic [`PTR_WIDTH-1:0] offs;
        lin = p - `LIN_BASE;
        bank = lin / `PTR_WIDTH'(`GPR_PER_BANK);
        offs = lin % `PTR_WIDTH'(`GPR_PER_BANK);
        if (p >= `LIN_BASE && p <= `LIN_LAST) begin
            dataMap = {bank[4:0], `GPR_FIRST + offs[6:0]};
        end else begin
            dataMap = p[`DADDR_WIDTH-1:0];
        end
    endfunction

    // ****************************************
    // state
    // ****************************************
    logic [`STACK_CW-1:0] depth;
    logic [`PC_WIDTH-1:0] stackTop;
    ixstate_t ixState;
    logic [`PTR_WIDTH-1:0] shadowPtr0;
    logic [`PTR_WIDTH-1:0] shadowPtr1;

    // ****************************************
    // sequencing decode
    // ****************************************
    // only the flow-changing subset of the 49 reaches this block
    wire isCall = (seqOp == SEQ_CALL);
    wire isIrq = (seqOp == SEQ_IRQ);
    wire isRet = (seqOp == SEQ_RETURN) || (seqOp == SEQ_RETFIE);
    wire busy = (ixState != IX_IDLE);
    // the soft reset cycle ignores every sequencing op
    wire frozen = busy || softReset;
    wire doPush = !frozen && (isCall || isIrq);
    wire doPop = !frozen && isRet;
    wire full = (depth == `STACK_CW'(`STACK_DEPTH));
    wire empty = (depth == '0);
    wire overflowEv = doPush && full;
    wire underflowEv = doPop && empty;
    wire stackFault = stackResetEnable && (overflowEv || underflowEv);
    wire [`PC_WIDTH-1:0] pcPlus = wrapPc(pc + `PC_WIDTH'(1));
    wire [`STACK_CW-1:0] next_depth =
        (doPush && !full) ? depth + `STACK_CW'(1) :
        (doPop && !empty) ? depth - `STACK_CW'(1) : depth;
    wire [`STACK_AW-1:0] pushSlot = depth[`STACK_AW-1:0];
    wire [`STACK_AW-1:0] topSlot = next_depth[`STACK_AW-1:0] - `STACK_AW'(1);

    // ****************************************
    // program counter next value
    // ****************************************
    logic [`PC_WIDTH-1:0] next_pc;
    always_comb begin
        next_pc = pc;
        if (stackFault) begin
            next_pc = `RESET_VECTOR;
        end else if (!busy) begin
            case (seqOp)
                SEQ_NEXT: next_pc = pcPlus;
                SEQ_JUMP: next_pc = wrapPc(jumpTarget);
                SEQ_CALL: next_pc = wrapPc(jumpTarget);
                SEQ_IRQ: next_pc = `IRQ_VECTOR;
                SEQ_RETURN, SEQ_RETFIE: begin
                    // empty pop keeps running in line
                    next_pc = empty ? pcPlus : wrapPc(stackTop);
                end
                default: next_pc = pc;
            endcase
        end
    end

    return_stack_mem u_stack (
        .clk_sys(clk_sys),
        .we(doPush && !full),
        .wrAddr(pushSlot),
        .wrData(pcPlus),
        .rdAddr(topSlot),
        .rdData(stackTop)
    );

    // ****************************************
    // indirect access decode
    // ****************************************
    wire [`PTR_WIDTH-1:0] selPtr = indSel ? ptr1 : ptr0;
    wire toPmem = selPtr[`PTR_PMEM_BIT];
    wire startPm = !busy && indReq && toPmem && !indWrite;
    wire startData = !busy && indReq && !toPmem;
    wire [`PMEM_AW-1:0] pmPtrAddr = selPtr[`PMEM_AW-1:0];
    wire [`PMEM_AW-1:0] next_progAddr =
        startPm ? pmPtrAddr : next_pc[`PMEM_AW-1:0];
    wire retfieNow = !frozen && (seqOp == SEQ_RETFIE);
    wire irqNow = !frozen && isIrq;

    // ****************************************
    // registers
    // ****************************************
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            pc <= `RESET_VECTOR;
            progAddr <= '0;
            depth <= '0;
            softReset <= 1'b0;
        end else if (softReset) begin
            pc <= `RESET_VECTOR;
            progAddr <= '0;
            depth <= '0;
            softReset <= 1'b0;
        end else begin
            pc <= next_pc;
            progAddr <= next_progAddr;
            depth <= next_depth;
            softReset <= stackFault;
        end
    end

    // set wins over a clear in the same cycle
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            stack_overflow_flag <= 1'b0;
            stack_underflow_flag <= 1'b0;
        end else begin
            stack_overflow_flag <= overflowEv ||
                (stack_overflow_flag && !clearStackFlags);
            stack_underflow_flag <= underflowEv ||
                (stack_underflow_flag && !clearStackFlags);
        end
    end

    // program-memory reads hold the pipe one cycle for the word fetch
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            ixState <= IX_IDLE;
            stall <= 1'b0;
            indRdata <= '0;
            indRdValid <= 1'b0;
        end else begin
            indRdValid <= 1'b0;
            case (ixState)
                IX_IDLE: begin
                    if (startPm) begin
                        ixState <= IX_PMWAIT;
                        stall <= 1'b1;
                    end
                end
                IX_PMWAIT: begin
                    ixState <= IX_IDLE;
                    stall <= 1'b0;
                    indRdata <= progData[7:0];
                    indRdValid <= 1'b1;
                end
                default: ixState <= IX_IDLE;
            endcase
        end
    end

    // program-space writes never reach the data bus
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            dataAddr <= '0;
            dataRe <= 1'b0;
            dataWe <= 1'b0;
            dataWdata <= '0;
        end else begin
            dataRe <= startData && !indWrite;
            dataWe <= startData && indWrite;
            if (startData) begin
                dataAddr <= dataMap(selPtr);
                dataWdata <= indWdata;
            end
        end
    end

    // ****************************************
    // pointers and shadows
    // ****************************************
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : gPtr
            logic [`PTR_WIDTH-1:0] val;
            wire [`PTR_WIDTH-1:0] shadow = (g == 0) ? shadowPtr0 : shadowPtr1;
            always_ff @(posedge clk_sys or negedge resetn) begin
                if (!resetn) begin
                    val <= '0;
                end else if (retfieNow) begin
                    val <= shadow;
                end else if (ptrWrite[g] && ptrHighByte) begin
                    val[15:8] <= ptrWdata;
                end else if (ptrWrite[g]) begin
                    val[7:0] <= ptrWdata;
                end
            end
        end
    endgenerate

    assign ptr0 = gPtr[0].val;
    assign ptr1 = gPtr[1].val;

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            shadowWreg <= '0;
            shadowStatus <= '0;
            shadowBsr <= '0;
            shadowPclath <= '0;
            shadowPtr0 <= '0;
            shadowPtr1 <= '0;
            restoreValid <= 1'b0;
        end else begin
            restoreValid <= retfieNow;
            if (irqNow) begin
                shadowWreg <= ctxWreg;
                shadowStatus <= ctxStatus;
                shadowBsr <= ctxBsr;
                shadowPclath <= ctxPclath;
                shadowPtr0 <= ptr0;
                shadowPtr1 <= ptr1;
            end
        end
    end
endmodule

// [cpu_pc_stack_fsr_core_chk.sv]
`timescale 1ns/1ns
`include "cpu_core_params.svh"
module cpu_pc_stack_fsr_core_chk
    import cpu_core_pkg::*;
(
    input wire logic clk_sys,
    input wire logic resetn,
    input wire seqop_t seqOp,
    input wire logic stackResetEnable,
    input wire logic clearStackFlags,
    input wire logic indReq,
    input wire logic indWrite,
    input wire logic indSel,
    input wire logic [`PWORD_WIDTH-1:0] progData,
    input wire logic [`PC_WIDTH-1:0] pc,
    input wire logic [`PMEM_AW-1:0] progAddr,
    input wire logic stall,
    input wire logic [7:0] indRdata,
    input wire logic indRdValid,
    input wire logic dataWe,
    input wire logic [`PTR_WIDTH-1:0] ptr0,
    input wire logic [`PTR_WIDTH-1:0] ptr1,
    input wire logic stack_overflow_flag,
    input wire logic softReset
);
    wire logic selPm;
    wire logic [7:0] progLow;
    assign selPm = indSel ? ptr1[15] : ptr0[15];
    assign progLow = progData[7:0];
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    AST_PC_WRAP: assert property (pc[14:12] == 3'h0)
        else $error("pc left implemented program space");
    AST_FETCH_ADDR: assert property (!stall |-> progAddr == pc[11:0])
        else $error("fetch address differs from pc");
    AST_IRQ_VECTOR: assert property (seqOp == SEQ_IRQ && !stall && !softReset
        |=> pc == `IRQ_VECTOR || softReset)
        else $error("interrupt entry not at vector");
    AST_STALL_ONE: assert property (stall |=> !stall)
        else $error("stall longer than one cycle");
    AST_PM_READ: assert property (indReq && !indWrite && selPm && !stall
        |=> stall ##1 (indRdValid && !stall))
        else $error("program read timing wrong");
    AST_RD_DATA: assert property (indRdValid |-> indRdata == $past(progLow))
        else $error("read byte not low byte of word");
    AST_PM_WRITE: assert property (indReq && indWrite && selPm && !stall
        |=> !dataWe && !stall)
        else $error("program write had an effect");
    AST_SOFT_RESET: assert property (softReset |-> pc == 15'h0 ##1
        (pc == 15'h0 && !softReset))
        else $error("soft reset sequence wrong");
    AST_SOFT_CAUSE: assert property (softReset |-> $past(stackResetEnable))
        else $error("soft reset without enable");
    AST_OVF_HOLD: assert property (stack_overflow_flag && !clearStackFlags
        |=> stack_overflow_flag)
        else $error("overflow flag dropped");
    CV_IRQ: cover property (seqOp == SEQ_IRQ ##1 pc == `IRQ_VECTOR);
    CV_STALL: cover property (stall ##1 indRdValid);
    CV_SOFT: cover property (softReset);
    CV_OVF: cover property ($rose(stack_overflow_flag));
endmodule

// [cpu_pc_stack_fsr_core_test.sv]
`timescale 1ns/1ns
`include "cpu_core_params.svh"
module cpu_pc_stack_fsr_core_test
    import cpu_core_pkg::*;
;
    logic clk_sys = 0, resetn = 0, stackResetEnable = 0, clearStackFlags = 0;
    seqop_t seqOp = SEQ_HOLD;
    logic [14:0] jumpTarget = 0, pc, pcOld;
    logic [7:0] ctxWreg = 0, ptrWdata = 0, indWdata = 0, indRdata, dataWdata;
    logic [4:0] ctxStatus = 0, ctxBsr = 0, shadowStatus, shadowBsr;
    logic [6:0] ctxPclath = 0, shadowPclath;
    logic [1:0] ptrWrite = 0;
    logic ptrHighByte = 0, indReq = 0, indWrite = 0, indSel = 0;
    logic [13:0] progData;
    logic [11:0] progAddr, dataAddr;
    logic [15:0] ptr0, ptr1;
    logic stall, indRdValid, dataRe, dataWe, ovf, unf, softReset, restoreValid;
    logic [7:0] shadowWreg;
    int err_count = 0, comparisons = 0;
    cpu_pc_stack_fsr_core i_dut (.clk_sys(clk_sys), .resetn(resetn),
        .seqOp(seqOp), .jumpTarget(jumpTarget),
        .stackResetEnable(stackResetEnable), .clearStackFlags(clearStackFlags),
        .ctxWreg(ctxWreg), .ctxStatus(ctxStatus), .ctxBsr(ctxBsr),
        .ctxPclath(ctxPclath), .ptrWrite(ptrWrite), .ptrHighByte(ptrHighByte),
        .ptrWdata(ptrWdata), .indReq(indReq), .indWrite(indWrite),
        .indSel(indSel), .indWdata(indWdata), .progData(progData), .pc(pc),
        .progAddr(progAddr), .stall(stall), .indRdata(indRdata),
        .indRdValid(indRdValid), .dataAddr(dataAddr), .dataRe(dataRe),
        .dataWe(dataWe), .dataWdata(dataWdata), .ptr0(ptr0), .ptr1(ptr1),
        .stack_overflow_flag(ovf), .stack_underflow_flag(unf),
        .softReset(softReset), .restoreValid(restoreValid),
        .shadowWreg(shadowWreg), .shadowStatus(shadowStatus),
        .shadowBsr(shadowBsr), .shadowPclath(shadowPclath));
    prog_mem_model i_mem (.progAddr(progAddr), .progData(progData));
    initial begin
        forever #2 clk_sys = ~clk_sys;
    end
    // ****************************************
    // shared tasks
    // ****************************************
    task automatic chk(input string what, input logic [31:0] exp, got);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic op(input seqop_t o, input logic [14:0] t);
        seqOp = o;
        jumpTarget = t;
        @(negedge clk_sys);
    endtask
    task automatic rst(input int n);
        resetn = 0;
        repeat (n) @(negedge clk_sys);
        resetn = 1;
        chk("pc after reset", 0, pc);
    endtask
    // byte writes: high then low, strobe held across both
    task automatic setPtr(input logic sel, input logic [15:0] v);
        ptrWrite = sel ? 2'b10 : 2'b01;
        ptrHighByte = 1;
        ptrWdata = v[15:8];
        @(negedge clk_sys);
        ptrHighByte = 0;
        ptrWdata = v[7:0];
        @(negedge clk_sys);
        ptrWrite = 0;
        @(negedge clk_sys);
    endtask
    task automatic indAccess(input logic sel, input logic wr);
        indSel = sel;
        indWrite = wr;
        indReq = 1;
        @(negedge clk_sys);
        indReq = 0;
    endtask
    // ****************************************
    // scenarios
    // ****************************************
    task automatic testCallReturn();
        rst(2);
        op(SEQ_NEXT, 0);
        op(SEQ_NEXT, 0);
        op(SEQ_CALL, 15'h7abc);
        chk("call wraps", 15'h0abc, pc);
        op(SEQ_RETURN, 0);
        chk("return pc", 15'h0003, pc);
        op(SEQ_JUMP, 15'h0fff);
        op(SEQ_NEXT, 0);
        chk("pc past last word", 0, pc);
        op(SEQ_HOLD, 0);
    endtask
    task automatic testIrq();
        rst(2);
        setPtr(0, 16'h1234);
        ctxWreg = 8'ha5;
        ctxStatus = 5'h15;
        ctxBsr = 5'h0a;
        ctxPclath = 7'h5c;
        op(SEQ_NEXT, 0);
        op(SEQ_IRQ, 0);
        chk("irq vector", 15'h0004, pc);
        op(SEQ_HOLD, 0);
        // pointer moved inside the handler must come back on return
        setPtr(0, 16'h5678);
        ctxWreg = 8'h00;
        op(SEQ_RETFIE, 0);
        chk("shadows", {7'h5c, 5'h0a, 5'h15, 8'ha5},
            {shadowPclath, shadowBsr, shadowStatus, shadowWreg});
        chk("restore", 1, restoreValid);
        chk("pointer restored", 16'h1234, ptr0);
        chk("retfie pc", 15'h0002, pc);
        op(SEQ_HOLD, 0);
    endtask
    task automatic testStack();
        rst(2);
        for (int i = 0; i < 16; i++) op(SEQ_CALL, 15'(i * 16));
        chk("no overflow at 16", 0, ovf);
        op(SEQ_CALL, 15'h0200);
        chk("overflow", 1, ovf);
        clearStackFlags = 1;
        op(SEQ_HOLD, 0);
        clearStackFlags = 0;
        chk("flag cleared", 0, ovf);
        for (int i = 0; i < 16; i++) op(SEQ_RETURN, 0);
        chk("no underflow", 0, unf);
        pcOld = pc;
        op(SEQ_RETURN, 0);
        chk("underflow", 1, unf);
        chk("underflow pc", pcOld + 15'h1, pc);
        stackResetEnable = 1;
        op(SEQ_RETURN, 0);
        chk("soft reset", 1, softReset);
        op(SEQ_HOLD, 0);
        chk("soft reset pc", 0, pc);
        chk("flags kept", 1, unf);
        stackResetEnable = 0;
    endtask
    task automatic testIndirect();
        rst(2);
        setPtr(0, 16'h8123);
        setPtr(1, 16'h2050);
        chk("pointers", 32'h81232050, {ptr0, ptr1});
        indAccess(0, 0);
        chk("stall", 1, stall);
        chk("pm address", 12'h123, progAddr);
        @(negedge clk_sys);
        chk("stall end", 0, stall);
        chk("pm byte", {1'b1, 8'h86}, {indRdValid, indRdata});
        indAccess(0, 1);
        chk("pm write", 0, {dataWe, stall});
        @(negedge clk_sys);
        indWdata = 8'h3c;
        indAccess(1, 1);
        chk("linear write", {1'b1, 12'h0a0, 8'h3c},
            {dataWe, dataAddr, dataWdata});
        // outside the linear window the pointer addresses registers as is
        setPtr(0, 16'h0123);
        indAccess(0, 0);
        chk("plain read", {1'b1, 1'b0, 12'h123},
            {dataRe, dataWe, dataAddr});
        indWrite = 0;
    endtask
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        #200000;
        err_count++;
        print_verdict();
    end
    initial begin
        rst(16);
        testCallReturn();
        testIrq();
        testStack();
        testIndirect();
        print_verdict();
    end
endmodule
bind cpu_pc_stack_fsr_core cpu_pc_stack_fsr_core_chk i_chk (
    .clk_sys(clk_sys), .resetn(resetn), .seqOp(seqOp),
    .stackResetEnable(stackResetEnable), .clearStackFlags(clearStackFlags),
    .indReq(indReq), .indWrite(indWrite), .indSel(indSel),
    .progData(progData), .pc(pc), .progAddr(progAddr), .stall(stall),
    .indRdata(indRdata), .indRdValid(indRdValid), .dataWe(dataWe),
    .ptr0(ptr0), .ptr1(ptr1), .stack_overflow_flag(stack_overflow_flag),
    .softReset(softReset));

// [prog_mem_model.sv]
`timescale 1ns/1ns
// ****************************************
// program memory stand-in, answers at once
// ****************************************
module prog_mem_model (
    input wire logic [11:0] progAddr,
    output logic [13:0] progData
);
    // 4096 words; the low byte differs for addresses that differ in bits 7:0, exposing wrong fetches
    assign progData = {2'b10, progAddr ^ 12'h5a5};
endmodule

// [return_stack_mem.sv]
`timescale 1ns/1ns
`include "cpu_core_params.svh"

// ****************************************
// return address memory, registered read
// ****************************************
module return_stack_mem
    import cpu_core_pkg::*;
(
    input wire logic clk_sys,
    input wire logic we,
    input wire logic [`STACK_AW-1:0] wrAddr,
    input wire logic [`PC_WIDTH-1:0] wrData,
    input wire logic [`STACK_AW-1:0] rdAddr,
    output logic [`PC_WIDTH-1:0] rdData
);
    logic [`PC_WIDTH-1:0] mem [0:`STACK_DEPTH-1];

    always_ff @(posedge clk_sys) begin
        if (we) begin
            mem[wrAddr] <= wrData;
        end
    end

    // write-first so a call followed at once by a return sees its entry
    always_ff @(posedge clk_sys) begin
        if (we && wrAddr == rdAddr) begin
            rdData <= wrData;
        end else begin
            rdData <= mem[rdAddr];
        end
    end
endmodule
